// ===== tunable_filter_code_interpolator.sv
`timescale 1ns/1ps
`include "interp_regs.svh"
module tunable_filter_code_interpolator (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [14:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	output logic [7:0] reg_rdata_out,
	output logic reg_rvalid_out,
	output logic [7:0] center_capacitor_out,
	output logic [7:0] bandwidth_capacitor_out,
	output logic [7:0] match_capacitor_out
);
	// ==========================================
	// Reset release
	logic rst_sync1_r;
	logic rst_sync2_r;
	logic rst_n;
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_sync1_r <= 1'b0;
			rst_sync2_r <= 1'b0;
		end else begin
			rst_sync1_r <= 1'b1;
			rst_sync2_r <= rst_sync1_r;
		end
	end
	assign rst_n = rst_sync2_r;

	// ==========================================
	// Helpers
	// Signed 32-bit intermediates hold a falling coefficient and the 295 scale without overflow.
	function automatic logic [7:0] lerp(input logic [7:0] base, input logic [7:0] other,
		input logic signed [31:0] weight, input logic [4:0] sh);
		logic signed [31:0] diff;
		logic signed [31:0] prod;
		diff = $signed({24'h00_0000, other}) - $signed({24'h00_0000, base});
		prod = (weight * diff) >>> sh;
		lerp = base + prod[7:0];
	endfunction : lerp

	function automatic logic [7:0] coeff_default(input logic [3:0] idx);
		logic [7:0] val;
		val = `RST_CENTER_0;
		unique case (idx)
			4'h0: val = `RST_CENTER_0;
			4'h1: val = `RST_CENTER_1;
			4'h2: val = `RST_CENTER_2;
			4'h3: val = `RST_CENTER_3;
			4'h4: val = `RST_CENTER_4;
			4'h5: val = `RST_CENTER_5;
			4'h6: val = `RST_CENTER_6;
			4'h7: val = `RST_CENTER_7;
			4'h8: val = `RST_CENTER_8;
			4'h9: val = `RST_CENTER_9;
			4'hA: val = `RST_BW_0;
			4'hB: val = `RST_BW_1;
			4'hC: val = `RST_BW_2;
			4'hD: val = `RST_MATCH_0;
			4'hE: val = `RST_MATCH_1;
			4'hF: val = `RST_MATCH_2;
		endcase
		coeff_default = val;
	endfunction : coeff_default

	// Second stage of the code chain: one of bandwidth or match from the center code.
	function automatic logic [7:0] second_stage(input logic [7:0] y, input logic [7:0] c0,
		input logic [7:0] c1, input logic [7:0] c2);
		logic [7:0] res;
		if (y < `SEG_SECOND) begin
			res = lerp(c0, c1, $signed({24'h00_0000, y}), `SHIFT_COARSE);
		end else if (y < `CODE_TOP) begin
			res = lerp(c1, c2, $signed({24'h00_0000, y - `SEG_SECOND}) * $signed(`BW_SCALE),
				`SHIFT_WIDE);
		end else begin
			res = c2;
		end
		second_stage = res;
	endfunction : second_stage

	// ==========================================
	// Register file
	interp_pkg::reg_req_type req;
	interp_pkg::codes_type load_r;
	interp_pkg::codes_type load_nxt;
	logic interp_en_r;
	logic interp_en_nxt;
	logic [7:0] coeff_r [16];
	logic [7:0] coeff_nxt [16];
	logic [3:0] coeff_idx;
	logic coeff_hit;
	interp_pkg::codes_type applied_r;
	interp_pkg::codes_type applied_nxt;
	logic [7:0] rdata_nxt;

	assign req = '{wr: reg_wr_in, rd: reg_rd_in, addr: reg_addr_in, wdata: reg_wdata_in};
	assign coeff_hit = (req.addr >= `ADDR_COEFF_BASE) && (req.addr <= `ADDR_COEFF_LAST);
	assign coeff_idx = req.addr[3:0];

	always_comb begin
		load_nxt = load_r;
		interp_en_nxt = interp_en_r;
		coeff_nxt = coeff_r;
		if (req.wr) begin
			unique case (req.addr)
				`ADDR_CENTER_LOAD: load_nxt.center = req.wdata;
				`ADDR_BW_LOAD: load_nxt.bw = req.wdata;
				`ADDR_MATCH_LOAD: load_nxt.match = req.wdata;
				`ADDR_INTERP_CTRL: interp_en_nxt = req.wdata[`INTERP_EN_BIT];
				default: begin
					if (coeff_hit) begin
						coeff_nxt[coeff_idx] = req.wdata;
					end
				end
			endcase
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		unique case (req.addr)
			`ADDR_CENTER_LOAD: rdata_nxt = load_r.center;
			`ADDR_BW_LOAD: rdata_nxt = load_r.bw;
			`ADDR_MATCH_LOAD: rdata_nxt = load_r.match;
			`ADDR_INTERP_CTRL: rdata_nxt = {7'h00, interp_en_r};
			`ADDR_APPLIED_0: rdata_nxt = applied_r.center;
			`ADDR_APPLIED_1: rdata_nxt = applied_r.bw;
			`ADDR_APPLIED_2: rdata_nxt = applied_r.match;
			default: begin
				if (coeff_hit) begin
					rdata_nxt = coeff_r[coeff_idx];
				end
			end
		endcase
	end

	// ==========================================
	// Center code interpolation
	logic [7:0] x;
	logic [7:0] y;
	logic [8:0] seg_end;
	logic [3:0] seg_hi;
	assign x = load_r.center;
	assign seg_end = {1'b0, x[7:5], 5'h00} + 9'h020;
	assign seg_hi = {1'b0, x[7:5]} + 4'h1;

	always_comb begin
		if (x < `SEG_FIRST) begin
			y = lerp(coeff_r[1], coeff_r[0], $signed({24'h00_0000, `SEG_FIRST - x}), `SHIFT_FINE);
		end else if (x < `SEG_SECOND) begin
			y = lerp(coeff_r[2], coeff_r[1], $signed({24'h00_0000, `SEG_SECOND - x}), `SHIFT_FINE);
		end else if (x == `CODE_TOP) begin
			y = coeff_r[9];
		end else begin
			// Segment k ends at 32*(k+1); its near end is coefficient k+1, its far end k+2.
			y = lerp(coeff_r[seg_hi + 4'h1], coeff_r[seg_hi],
				$signed({23'h00_0000, seg_end}) - $signed({24'h00_0000, x}), `SHIFT_COARSE);
		end
	end

	// ==========================================
	// Code selection
	always_comb begin
		if (interp_en_r) begin
			applied_nxt.center = y;
			applied_nxt.bw = second_stage(y, coeff_r[10], coeff_r[11], coeff_r[12]);
			applied_nxt.match = second_stage(y, coeff_r[13], coeff_r[14], coeff_r[15]);
		end else begin
			applied_nxt = load_r;
		end
	end

	// ==========================================
	// State registers
	always_ff @(posedge core_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			load_r <= '{center: `RST_LOAD, bw: `RST_LOAD, match: `RST_LOAD};
			interp_en_r <= 1'b0;
			for (int i = 0; i < 16; i++) begin
				coeff_r[i] <= coeff_default(4'(i));
			end
			applied_r <= '{center: `RST_LOAD, bw: `RST_LOAD, match: `RST_LOAD};
			reg_rdata_out <= 8'h00;
			reg_rvalid_out <= 1'b0;
		end else begin
			load_r <= load_nxt;
			interp_en_r <= interp_en_nxt;
			coeff_r <= coeff_nxt;
			applied_r <= applied_nxt;
			reg_rdata_out <= req.rd ? rdata_nxt : 8'h00;
			reg_rvalid_out <= req.rd;
		end
	end

	assign center_capacitor_out = applied_r.center;
	assign bandwidth_capacitor_out = applied_r.bw;
	assign match_capacitor_out = applied_r.match;
endmodule : tunable_filter_code_interpolator

// ===== interp_regs.svh
// Behaviour
// - Enable bit makes all codes from center
// - Center input 0..255 maps monotonic
// - Below 16 interp_enable coeff1..coeff0, shift 4
// - 16 to 32 interp_enable coeff2..coeff1, shift 4
// - Segments of 32 up to 224, shift 5
// - 224..254 uses coeff9/coeff8; 255 gives coeff9
// - Bandwidth and match take center code
// - Bandwidth below 32 interpolates bw0..bw1
// - Bandwidth 32..254 uses 295 scale, shift 16
// - Match below 32 interpolates match0..match1
// - Match 32..254 uses 295 scale, shift 16
// - Coefficients reset to nominal set, writable
// - Readback shows codes actually applied
// - All loads and codes are 8 bits
// - Direct loads live at 0x020..0x022
`ifndef INTERP_REGS_SVH
`define INTERP_REGS_SVH
// ==========================================
// Register offsets
`define ADDR_CENTER_LOAD 15'h0020
`define ADDR_BW_LOAD 15'h0021
`define ADDR_MATCH_LOAD 15'h0022
`define ADDR_INTERP_CTRL 15'h0050
`define ADDR_APPLIED_0 15'h0060
`define ADDR_APPLIED_1 15'h0061
`define ADDR_APPLIED_2 15'h0062
`define ADDR_COEFF_BASE 15'h0070
`define ADDR_COEFF_LAST 15'h007F
`define INTERP_EN_BIT 0
// ==========================================
// Reset values of the coefficients, nominal bandwidth set, and of the loads and applied codes
`define RST_CENTER_0 8'hDA
`define RST_CENTER_1 8'hB0
`define RST_CENTER_2 8'h8E
`define RST_CENTER_3 8'h66
`define RST_CENTER_4 8'h4B
`define RST_CENTER_5 8'h37
`define RST_CENTER_6 8'h2A
`define RST_CENTER_7 8'h20
`define RST_CENTER_8 8'h18
`define RST_CENTER_9 8'h13
`define RST_BW_0 8'h01
`define RST_BW_1 8'h05
`define RST_BW_2 8'h27
`define RST_MATCH_0 8'h05
`define RST_MATCH_1 8'h19
`define RST_MATCH_2 8'h8A
`define RST_LOAD 8'h00
// ==========================================
// Arithmetic constants
`define BW_SCALE 32'h0000_0127
`define SHIFT_FINE 5'h04
`define SHIFT_COARSE 5'h05
`define SHIFT_WIDE 5'h10
`define SEG_FIRST 8'h10
`define SEG_SECOND 8'h20
`define CODE_TOP 8'hFF
`endif

// ===== interp_pkg.sv
package interp_pkg;
	// ==========================================
	// Shared types
	typedef struct packed {
		logic [7:0] center;
		logic [7:0] bw;
		logic [7:0] match;
	} codes_type;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [14:0] addr;
		logic [7:0] wdata;
	} reg_req_type;
endpackage : interp_pkg

// ===== tunable_filter_code_interpolator_props.sv
`timescale 1ns/1ps
`include "interp_regs.svh"
module interp_checker (
	input wire logic core_clk_in,
	input wire logic nrst_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	input wire logic [14:0] reg_addr_in,
	input wire logic [7:0] reg_wdata_in,
	input wire logic [7:0] reg_rdata_out,
	input wire logic reg_rvalid_out,
	input wire logic [7:0] center_capacitor_out,
	input wire logic [7:0] bandwidth_capacitor_out,
	input wire logic [7:0] match_capacitor_out
);
	// ==========================================
	// Shadow of the direct loads and the enable, so bypass can be judged from the ports alone.
	logic en_r, en_nxt;
	logic [7:0] ldc_r, ldc_nxt, ldb_r, ldb_nxt, ldm_r, ldm_nxt;
	always_comb begin
		en_nxt = (reg_wr_in && reg_addr_in == `ADDR_INTERP_CTRL) ? reg_wdata_in[0] : en_r;
		ldc_nxt = (reg_wr_in && reg_addr_in == `ADDR_CENTER_LOAD) ? reg_wdata_in : ldc_r;
		ldb_nxt = (reg_wr_in && reg_addr_in == `ADDR_BW_LOAD) ? reg_wdata_in : ldb_r;
		ldm_nxt = (reg_wr_in && reg_addr_in == `ADDR_MATCH_LOAD) ? reg_wdata_in : ldm_r;
	end
	always_ff @(posedge core_clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			{en_r, ldc_r, ldb_r, ldm_r} <= 25'h000_0000;
		end else begin
			{en_r, ldc_r, ldb_r, ldm_r} <= {en_nxt, ldc_nxt, ldb_nxt, ldm_nxt};
		end
	end
	// ==========================================
	// Properties
	default clocking dc @(posedge core_clk_in); endclocking
	default disable iff (!nrst_in);
	sequence s_rd(logic [14:0] a);
		reg_rd_in && reg_addr_in == a;
	endsequence
	a_read_answer: assert property (reg_rd_in |=> reg_rvalid_out) else $error("read not answered");
	a_no_spurious: assert property (!reg_rd_in |=> !reg_rvalid_out) else $error("stray read valid");
	a_center_readback: assert property (s_rd(`ADDR_APPLIED_0) |=>
		reg_rdata_out == $past(center_capacitor_out)) else $error("center readback differs");
	a_match_readback: assert property (s_rd(`ADDR_APPLIED_2) |=>
		reg_rdata_out == $past(match_capacitor_out)) else $error("match readback differs");
	a_bypass_center: assert property (!$past(en_r) |-> center_capacitor_out == $past(ldc_r))
		else $error("center bypass wrong");
	a_bypass_bw: assert property (!$past(en_r) |-> bandwidth_capacitor_out == $past(ldb_r))
		else $error("bandwidth bypass wrong");
	a_bypass_match: assert property (!$past(en_r) |-> match_capacitor_out == $past(ldm_r))
		else $error("match bypass wrong");
	a_codes_stable: assert property (!$past(reg_wr_in) && !$past(reg_wr_in, 2) |->
		$stable({center_capacitor_out, bandwidth_capacitor_out, match_capacitor_out})) else $error("codes moved");
endmodule : interp_checker
bind tunable_filter_code_interpolator interp_checker u_interp_checker (.core_clk_in, .nrst_in, .reg_wr_in,
	.reg_rd_in, .reg_addr_in, .reg_wdata_in, .reg_rdata_out, .reg_rvalid_out, .center_capacitor_out,
	.bandwidth_capacitor_out, .match_capacitor_out);

// ===== tb_tunable_filter_code_interpolator.sv
`timescale 1ns/1ps
`include "interp_regs.svh"
module tb_tunable_filter_code_interpolator;
	logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, rv;
	logic [14:0] addr = 15'h0000;
	logic [7:0] wd = 8'h00, rdat, cc, bc, mc;
	int bad_count = 0, checks_done = 0;
	int c[16];
	logic [7:0] x8;
	logic [23:0] want;
	// Each row is the center load, then the center, bandwidth and match codes that the nominal set gives.
	logic [31:0] rows[13] = '{32'h00DA_2177, 32'h0FB2_1B63, 32'h10B0_1B62, 32'h12AB_1A5F, 32'h1F90_1651,
		32'h208E_1550, 32'h3F67_0F3D, 32'h4066_0F3C, 32'hB423_051A, 32'hDF18_0414, 32'hE018_0414,
		32'hFE13_0310, 32'hFF13_0310};
	tunable_filter_code_interpolator u_tunable_filter_code_interpolator (.core_clk_in(clk), .nrst_in(nrst),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdat),
		.reg_rvalid_out(rv), .center_capacitor_out(cc), .bandwidth_capacitor_out(bc), .match_capacitor_out(mc));
	initial forever #20 clk = ~clk;
	// ==========================================
	// Helpers
	task close_out;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : close_out
	task chk(input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e) begin
			bad_count++;
			$display("mismatch %0t got %h expected %h", $time, s, e);
		end
	endtask : chk
	task wrt(input logic [14:0] a, input logic [7:0] d);
		@(negedge clk);
		{wr, addr, wd} = {1'b1, a, d};
		@(negedge clk);
		wr = 1'b0;
	endtask : wrt
	task rdb(input logic [14:0] a, input logic [7:0] e);
		@(negedge clk);
		{rd, addr} = {1'b1, a};
		@(negedge clk);
		rd = 1'b0;
		chk({7'h00, rv}, 8'h01);
		chk(rdat, e);
	endtask : rdb
	// Signed int arithmetic keeps negative differences intact before the floor shift.
	function automatic logic [7:0] lin(int b, int w, int d, int s);
		return 8'(b + ((w * d) >>> s));
	endfunction : lin
	function automatic logic [7:0] yf(int x);
		if (x < 16) return lin(c[1], 16 - x, c[0] - c[1], 4);
		if (x < 32) return lin(c[2], 32 - x, c[1] - c[2], 4);
		if (x < 255) return lin(c[x / 32 + 2], 32 * (x / 32 + 1) - x, c[x / 32 + 1] - c[x / 32 + 2], 5);
		return 8'(c[9]);
	endfunction : yf
	function automatic logic [7:0] vf(int y, int i);
		if (y < 32) return lin(c[i], y, c[i + 1] - c[i], 5);
		if (y < 255) return lin(c[i + 1], (y - 32) * 295, c[i + 2] - c[i + 1], 16);
		return 8'(c[i + 2]);
	endfunction : vf
	// ==========================================
	// Sequence
	initial begin
		repeat (20000) @(posedge clk);
		bad_count++;
		close_out;
	end
	initial begin
		c = '{218, 176, 142, 102, 75, 55, 42, 32, 24, 19, 1, 5, 39, 5, 25, 138};
		repeat (8) @(negedge clk);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		for (int i = 0; i < 16; i++) rdb(15'h0070 + 15'(i), 8'(c[i]));
		rdb(`ADDR_INTERP_CTRL, 8'h00);
		wrt(`ADDR_CENTER_LOAD, 8'h5A);
		wrt(`ADDR_BW_LOAD, 8'hC3);
		wrt(`ADDR_MATCH_LOAD, 8'h3C);
		wrt(`ADDR_APPLIED_1, 8'hFF);
		repeat (2) @(negedge clk);
		chk(cc, 8'h5A);
		chk(bc, 8'hC3);
		chk(mc, 8'h3C);
		rdb(`ADDR_APPLIED_1, 8'hC3);
		rdb(15'h7FFF, 8'h00);
		wrt(`ADDR_INTERP_CTRL, 8'h01);
		for (int p = 0; p < 2; p++) begin
			for (int i = 0; i < 13; i++) begin
				x8 = rows[i][31:24];
				wrt(`ADDR_CENTER_LOAD, x8);
				repeat (2) @(negedge clk);
				want = (p == 0) ? rows[i][23:0] : {yf(x8), vf(yf(x8), 10), vf(yf(x8), 13)};
				chk(cc, want[23:16]);
				chk(bc, want[15:8]);
				chk(mc, want[7:0]);
				rdb(`ADDR_APPLIED_2, want[7:0]);
			end
			if (p == 0) begin
				wrt(`ADDR_CENTER_LOAD, 8'h20);
				wrt(15'h007B, 8'h09);
				wrt(15'h007E, 8'h1E);
				wrt(`ADDR_CENTER_LOAD, 8'hB4);
				wrt(15'h007C, 8'h00);
				wrt(`ADDR_CENTER_LOAD, 8'h12);
				wrt(15'h007D, 8'hF0);
				wrt(15'h0073, 8'hC8);
				c[11] = 9;
				c[14] = 30;
				c[12] = 0;
				c[13] = 240;
				c[3] = 200;
				rdb(15'h007B, 8'h09);
			end
		end
		// A center code of 255 must select the last bandwidth and match coefficients.
		wrt(15'h0079, 8'hFF);
		wrt(`ADDR_CENTER_LOAD, 8'hFF);
		repeat (2) @(negedge clk);
		chk(cc, 8'hFF);
		chk(bc, 8'h00);
		chk(mc, 8'h8A);
		rdb(`ADDR_APPLIED_0, 8'hFF);
		@(negedge clk);
		chk(rdat, 8'h00);
		chk({7'h00, rv}, 8'h00);
		// A write and a read of the enable in one cycle: the read returns the old value.
		@(negedge clk);
		{wr, rd, addr, wd} = {1'b1, 1'b1, `ADDR_INTERP_CTRL, 8'h00};
		@(negedge clk);
		{wr, rd} = 2'b00;
		chk(rdat, 8'h01);
		repeat (2) @(negedge clk);
		chk(cc, 8'hFF);
		chk(bc, 8'hC3);
		chk(mc, 8'h3C);
		// Reset again in mid-run: coefficients return to the nominal set and the loads to zero.
		nrst = 1'b0;
		repeat (8) @(negedge clk);
		chk(cc, 8'h00);
		nrst = 1'b1;
		repeat (3) @(negedge clk);
		chk(cc, 8'h00);
		chk(bc, 8'h00);
		chk(mc, 8'h00);
		rdb(15'h0073, 8'h66);
		rdb(15'h0079, 8'h13);
		rdb(`ADDR_INTERP_CTRL, 8'h00);
		close_out;
	end
endmodule : tb_tunable_filter_code_interpolator
